/* pcib_pkg.sv */
`default_nettype none
package pcib_pkg;
  // configuration offsets (byte addresses)
  localparam logic [7:0] PCIB_OFS_CLASS_REVISION     = 8'h08;
  localparam logic [7:0] PCIB_OFS_LATENCY_CACHELINE  = 8'h0c;
  localparam logic [7:0] PCIB_OFS_IO_WINDOW_BASE     = 8'h10;
  localparam logic [7:0] PCIB_OFS_MEMORY_WINDOW_BASE = 8'h14;
  localparam logic [7:0] PCIB_OFS_SUBSYSTEM_IDENT    = 8'h2c;
  localparam logic [7:0] PCIB_OFS_EXPANSION_ROM_BASE = 8'h30;

  // fixed class fields
  localparam logic [7:0] PCIB_BASE_CLASS = 8'h02;
  localparam logic [7:0] PCIB_SUBCLASS   = 8'h00;

  // field positions
  localparam int PCIB_LAT_LSB      = 8;
  localparam int PCIB_IO_BASE_LSB  = 8;
  localparam int PCIB_MEM_BASE_LSB = 10;
  localparam int PCIB_ROM_BASE_LSB = 17;
  localparam int PCIB_IO_BASE_W    = 32 - PCIB_IO_BASE_LSB;
  localparam int PCIB_MEM_BASE_W   = 32 - PCIB_MEM_BASE_LSB;
  localparam int PCIB_ROM_BASE_W   = 32 - PCIB_ROM_BASE_LSB;

  // reset values
  localparam logic [7:0]  PCIB_LAT_RST      = 8'h00;
  localparam logic [7:0]  PCIB_CLS_RST      = 8'h00;
  localparam logic [23:0] PCIB_IO_BASE_RST  = 24'h000000;
  localparam logic [21:0] PCIB_MEM_BASE_RST = 22'h000000;
  localparam logic [14:0] PCIB_ROM_BASE_RST = 15'h0000;
  localparam logic        PCIB_ROM_EN_RST   = 1'b0;
  localparam logic [15:0] PCIB_SUBSYS_RST   = 16'h0000;

  // read-only indicator bits
  localparam logic PCIB_IO_SPACE_IND  = 1'b1;
  localparam logic PCIB_MEM_SPACE_IND = 1'b0;
endpackage
`default_nettype wire

/* pcib_lat_timer.sv */
`default_nettype none
module pcib_lat_timer
  import pcib_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // programmed value
  input  wire logic [7:0] lat_value,
  // master bus state
  input  wire logic       master_frame,
  input  wire logic       gnt_n,
  // status
  output logic            lat_expired,
  output logic            burst_stop
);
  logic [7:0] count_q, count_d;
  logic       frame_q, frame_d;
  logic       run_q, run_d;

  always_comb
  begin
    frame_d = master_frame;
    count_d = count_q;
    run_d   = run_q;
    if (master_frame && !frame_q)
    begin
      count_d = lat_value;
      run_d   = 1'b1;
    end
    else if (!master_frame)
      run_d = 1'b0;
    else if (count_q != 8'h00)
      count_d = count_q - 8'h01;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= 8'h00;
      frame_q <= 1'b0;
      run_q   <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      frame_q <= frame_d;
      run_q   <= run_d;
    end
  end

  // expiry only counts while our own frame is on the bus
  assign lat_expired = run_q && (count_q == 8'h00);
  assign burst_stop  = lat_expired && master_frame && gnt_n;
endmodule
`default_nettype wire

/* pcib_win_decode.sv */
`default_nettype none
module pcib_win_decode
  import pcib_pkg::*;
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  // access address
  input  wire logic [31:0]                acc_addr,
  // window bases and enables
  input  wire logic [PCIB_IO_BASE_W-1:0]  io_base,
  input  wire logic [PCIB_MEM_BASE_W-1:0] mem_base,
  input  wire logic [PCIB_ROM_BASE_W-1:0] rom_base,
  input  wire logic                       rom_enable,
  input  wire logic                       io_space_enable,
  input  wire logic                       memory_space_enable,
  // registered hits
  output logic                            io_hit,
  output logic                            mem_hit,
  output logic                            rom_hit
);
  logic io_d, mem_d, rom_d;

  always_comb
  begin
    io_d  = io_space_enable && (acc_addr[31:PCIB_IO_BASE_LSB] == io_base);
    mem_d = memory_space_enable
            && (acc_addr[31:PCIB_MEM_BASE_LSB] == mem_base);
    // rom answers only with both enables set
    rom_d = rom_enable && memory_space_enable
            && (acc_addr[31:PCIB_ROM_BASE_LSB] == rom_base);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_hit  <= 1'b0;
      mem_hit <= 1'b0;
      rom_hit <= 1'b0;
    end
    else
    begin
      io_hit  <= io_d;
      mem_hit <= mem_d;
      rom_hit <= rom_d;
    end
  end
endmodule
`default_nettype wire

/* pcib_config_bars.sv */
// Function
// - class word reads base class 02h, subclass 00h, both read-only
// - low byte holds read-only revision and step nibbles; bits 15..8 reserved
// - latency timer byte in bits 15..8, writable, resets to zero
// - latency timer starts counting from programmed value when our frame starts
// - timer expired with frame still asserted: stop burst once grant removed
// - cache line size byte in bits 7..0, writable, resets zero, units words
// - io base bits 31..8 writable, reset zero, place 256-byte register block
// - io base bit 0 reads one; bits 7..1 reserved
// - memory base bits 31..10 writable, reset zero; bit 0 reads zero
// - subsystem word: id high, vendor low, both read-only, loaded from eeprom
// - rom base upper bits writable, low address bits read zero for sizing
// - rom window decoded only when rom enable and memory space enable set
// - all-ones write to rom base reads back fffe0001
// - memory space enable is command bit 1; clear disables memory decode
`default_nettype none
module pcib_config_bars
  import pcib_pkg::*;
#(
  // arbitrary values, not tied to any part
  parameter logic [3:0] REVISION_VALUE = 4'h3,
  parameter logic [3:0] STEP_VALUE     = 4'h2
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  output logic             cfg_hit,
  // eeprom loader
  input  wire logic        ee_load,
  input  wire logic [15:0] ee_subsystem_id,
  input  wire logic [15:0] ee_subsystem_vendor,
  // command register bits
  input  wire logic        io_space_enable,
  input  wire logic        memory_space_enable,
  // master state machine
  input  wire logic        master_frame,
  input  wire logic        gnt_n,
  output logic             lat_expired,
  output logic             burst_stop,
  // target decode
  input  wire logic [31:0] acc_addr,
  output logic             io_hit,
  output logic             mem_hit,
  output logic             rom_hit,
  // programmed values for other blocks
  output logic [7:0]       cache_line_size
);
  logic                       sync1_q, sync2_q;
  logic                       rst_n;
  logic [7:0]                 lat_q, lat_d;
  logic [7:0]                 cls_q, cls_d;
  logic [PCIB_IO_BASE_W-1:0]  io_base_q, io_base_d;
  logic [PCIB_MEM_BASE_W-1:0] mem_base_q, mem_base_d;
  logic [PCIB_ROM_BASE_W-1:0] rom_base_q, rom_base_d;
  logic                       rom_en_q, rom_en_d;
  logic [15:0]                sub_id_q, sub_id_d;
  logic [15:0]                sub_ven_q, sub_ven_d;
  logic [31:0]                rdata_d;
  logic                       rvalid_d;
  logic [31:0]                wmask;
  logic                       lat_we, io_we, mem_we, rom_we;
  logic [31:0]                lat_word, io_word, mem_word, rom_word;

  // byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // masked merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [31:0] m);
    merge = (old_w & ~m) | (new_w & m);
  endfunction

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == PCIB_OFS_CLASS_REVISION) || (a == PCIB_OFS_LATENCY_CACHELINE)
                || (a == PCIB_OFS_IO_WINDOW_BASE) || (a == PCIB_OFS_MEMORY_WINDOW_BASE)
                || (a == PCIB_OFS_SUBSYSTEM_IDENT) || (a == PCIB_OFS_EXPANSION_ROM_BASE);
  endfunction

  // write strobe for one mapped offset
  function automatic logic wr_at(input logic       we,
                                 input logic [7:0] a,
                                 input logic [7:0] ofs);
    wr_at = we && (a == ofs);
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= 1'b1;
      sync2_q <= sync1_q;
    end
  end

  assign rst_n = sync2_q;

  assign wmask   = be_mask(cfg_be);
  assign cfg_hit = known_ofs(cfg_addr);

  // read-only words and unmapped offsets get no strobe, so writes vanish
  assign lat_we = wr_at(cfg_wr, cfg_addr, PCIB_OFS_LATENCY_CACHELINE);
  assign io_we  = wr_at(cfg_wr, cfg_addr, PCIB_OFS_IO_WINDOW_BASE);
  assign mem_we = wr_at(cfg_wr, cfg_addr, PCIB_OFS_MEMORY_WINDOW_BASE);
  assign rom_we = wr_at(cfg_wr, cfg_addr, PCIB_OFS_EXPANSION_ROM_BASE);

  // latency and cache line; upper half reserved, no storage there
  always_comb
  begin
    lat_word = merge({16'h0000, lat_q, cls_q}, cfg_wdata, wmask);
    lat_d    = lat_q;
    cls_d    = cls_q;
    if (lat_we)
    begin
      lat_d = lat_word[15:8];
      cls_d = lat_word[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lat_q <= PCIB_LAT_RST;
      cls_q <= PCIB_CLS_RST;
    end
    else
    begin
      lat_q <= lat_d;
      cls_q <= cls_d;
    end
  end

  // io and memory windows; low bits hardwired, only the base is kept
  always_comb
  begin
    io_word    = merge({io_base_q, 8'h00}, cfg_wdata, wmask);
    mem_word   = merge({mem_base_q, 10'h000}, cfg_wdata, wmask);
    io_base_d  = io_base_q;
    mem_base_d = mem_base_q;
    if (io_we)
      io_base_d = io_word[31:PCIB_IO_BASE_LSB];
    if (mem_we)
      mem_base_d = mem_word[31:PCIB_MEM_BASE_LSB];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_base_q  <= PCIB_IO_BASE_RST;
      mem_base_q <= PCIB_MEM_BASE_RST;
    end
    else
    begin
      io_base_q  <= io_base_d;
      mem_base_q <= mem_base_d;
    end
  end

  // rom base and enable; enable rides on byte lane 0
  always_comb
  begin
    rom_word   = merge({rom_base_q, 16'h0000, rom_en_q}, cfg_wdata, wmask);
    rom_base_d = rom_base_q;
    rom_en_d   = rom_en_q;
    if (rom_we)
    begin
      rom_base_d = rom_word[31:PCIB_ROM_BASE_LSB];
      rom_en_d   = rom_word[0];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rom_base_q <= PCIB_ROM_BASE_RST;
      rom_en_q   <= PCIB_ROM_EN_RST;
    end
    else
    begin
      rom_base_q <= rom_base_d;
      rom_en_q   <= rom_en_d;
    end
  end

  // ids come only from the loader; no config write can reach them
  always_comb
  begin
    sub_id_d  = sub_id_q;
    sub_ven_d = sub_ven_q;
    if (ee_load)
    begin
      sub_id_d  = ee_subsystem_id;
      sub_ven_d = ee_subsystem_vendor;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_id_q  <= PCIB_SUBSYS_RST;
      sub_ven_q <= PCIB_SUBSYS_RST;
    end
    else
    begin
      sub_id_q  <= sub_id_d;
      sub_ven_q <= sub_ven_d;
    end
  end

  // read path; reserved bits are zero by construction
  always_comb
  begin
    rvalid_d = cfg_rd;
    rdata_d  = 32'h00000000;
    if (cfg_rd)
    begin
      unique case (cfg_addr)
        PCIB_OFS_CLASS_REVISION:
          rdata_d = {PCIB_BASE_CLASS, PCIB_SUBCLASS, 8'h00,
                     REVISION_VALUE, STEP_VALUE};
        PCIB_OFS_LATENCY_CACHELINE:
          rdata_d = {16'h0000, lat_q, cls_q};
        PCIB_OFS_IO_WINDOW_BASE:
          rdata_d = {io_base_q, 7'h00, PCIB_IO_SPACE_IND};
        PCIB_OFS_MEMORY_WINDOW_BASE:
          rdata_d = {mem_base_q, 9'h000, PCIB_MEM_SPACE_IND};
        PCIB_OFS_SUBSYSTEM_IDENT:
          rdata_d = {sub_id_q, sub_ven_q};
        PCIB_OFS_EXPANSION_ROM_BASE:
          rdata_d = {rom_base_q, 16'h0000, rom_en_q};
        // unmapped offsets read zero
        default:
          rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rdata  <= rdata_d;
      cfg_rvalid <= rvalid_d;
    end
  end

  assign cache_line_size = cls_q;

  pcib_lat_timer u_lat_timer
  (
    .clock        (clock),
    .rst_n        (rst_n),
    .lat_value    (lat_q),
    .master_frame (master_frame),
    .gnt_n        (gnt_n),
    .lat_expired  (lat_expired),
    .burst_stop   (burst_stop)
  );

  // rom decode relies on the host setting the base first
  pcib_win_decode u_win_decode
  (
    .clock               (clock),
    .rst_n               (rst_n),
    .acc_addr            (acc_addr),
    .io_base             (io_base_q),
    .mem_base            (mem_base_q),
    .rom_base            (rom_base_q),
    .rom_enable          (rom_en_q),
    .io_space_enable     (io_space_enable),
    .memory_space_enable (memory_space_enable),
    .io_hit              (io_hit),
    .mem_hit             (mem_hit),
    .rom_hit             (rom_hit)
  );
endmodule
`default_nettype wire

/* pcib_config_bars_props.sv */
`default_nettype none
module pcib_config_bars_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // configuration access
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_hit,
  // master and decode
  input wire logic        memory_space_enable,
  input wire logic        master_frame,
  input wire logic        gnt_n,
  input wire logic        lat_expired,
  input wire logic        burst_stop,
  input wire logic        mem_hit,
  input wire logic        rom_hit,
  input wire logic [7:0]  cache_line_size
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  AST_CLASS: assert property (cfg_rd && cfg_addr == 8'h08 |=> cfg_rdata[31:8] == 24'h020000)
    else $error("class word wrong");
  AST_LATHI: assert property (cfg_rd && cfg_addr == 8'h0c |=> cfg_rdata[31:16] == 16'h0000)
    else $error("latency word upper half not zero");
  AST_IOIND: assert property (cfg_rd && cfg_addr == 8'h10 |=> cfg_rdata[7:0] == 8'h01)
    else $error("io base low byte wrong");
  AST_MEMLO: assert property (cfg_rd && cfg_addr == 8'h14 |=> cfg_rdata[9:0] == 10'h000)
    else $error("memory base low bits wrong");
  AST_ROMLO: assert property (cfg_rd && cfg_addr == 8'h30 |=> cfg_rdata[16:1] == 16'h0000)
    else $error("rom base low bits not zero");
  AST_CLS: assert property (cfg_wr && cfg_addr == 8'h0c && cfg_be[0]
    |=> cache_line_size == $past(cfg_wdata[7:0])) else $error("cache line size not written");
  AST_STOP: assert property (burst_stop |-> lat_expired && master_frame && gnt_n)
    else $error("burst stop without cause");
  AST_EXPIRE: assert property (lat_expired |-> $past(master_frame))
    else $error("timer expired outside own frame");
  AST_ROMHIT: assert property (rom_hit |-> $past(memory_space_enable))
    else $error("rom hit with memory space disabled");
  AST_MEMHIT: assert property (mem_hit |-> $past(memory_space_enable))
    else $error("memory hit with memory space disabled");
  AST_HIT: assert property (cfg_rd |-> cfg_hit == (cfg_addr inside {8'h08, 8'h0c,
    8'h10, 8'h14, 8'h2c, 8'h30})) else $error("config hit wrong");
endmodule

bind pcib_config_bars pcib_config_bars_props u_props (.clock, .rstn, .cfg_wr, .cfg_rd,
  .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_hit, .memory_space_enable, .master_frame,
  .gnt_n, .lat_expired, .burst_stop, .mem_hit, .rom_hit, .cache_line_size);
`default_nettype wire

/* pcib_host_model.sv */
`default_nettype none
module pcib_host_model (
  // bus clock
  input  wire logic        clock,
  // configuration request
  output var logic         cfg_wr,
  output var logic         cfg_rd,
  output var logic [7:0]   cfg_addr,
  output var logic [3:0]   cfg_be,
  output var logic [31:0]  cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  // address and data lines scrambled after use so stale data never looks valid
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d);
    @(posedge clock);
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* pcib_config_bars_test.sv */
`default_nettype none
module pcib_config_bars_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pcib_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, ee_load = 1'b0, mse = 1'b0, frame = 1'b0, gnt_n = 1'b0;
  logic ise = 1'b0, io_hit;
  logic cfg_wr, cfg_rd, cfg_rvalid, lat_expired, burst_stop, mem_hit, rom_hit;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, v;
  logic [31:0] acc = 32'h0;
  logic [15:0] ee_id = 16'h0, ee_ven = 16'h0;
  logic [31:0] expq [$];
  int seed = 32'h13a0, errors = 0, n_compared = 0;
  logic [7:0]  adr [6] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h2c, 8'h30};
  logic [31:0] msk [6] = '{0, 32'hffff, 32'hffffff00, 32'hfffffc00, 0, 32'hfffe0001};
  logic [31:0] shd [6] = '{32'h02000032, 0, 1, 0, 0, 0};
  always #4 clock = ~clock;
  pcib_host_model u_host (.clock, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata);
  pcib_config_bars u_dut (.clock, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_rvalid, .cfg_hit(), .ee_load, .ee_subsystem_id(ee_id),
    .ee_subsystem_vendor(ee_ven), .io_space_enable(ise), .memory_space_enable(mse),
    .master_frame(frame), .gnt_n, .lat_expired, .burst_stop, .acc_addr(acc), .io_hit,
    .mem_hit, .rom_hit, .cache_line_size());
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    u_host.access(1'b0, a, 4'h0, 32'h0);
  endtask
  task automatic wr(input int i, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk[i];
    shd[i] = (shd[i] & ~bm) | (d & bm);
    u_host.access(1'b1, adr[i], be, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  always @(posedge clock)
    if (cfg_rvalid === 1'b1)
    begin
      if (expq.size() == 0)
        chk("cfg_rvalid", 0, 1);
      else
        chk("cfg_rdata", expq.pop_front(), cfg_rdata);
    end
  initial
  begin
    repeat (2000) @(posedge clock);
    errors++;
    test_done;
  end
  initial
  begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    v = $random(seed);
    ee_id <= v[31:16];
    ee_ven <= v[15:0];
    ee_load <= 1'b1;
    shd[4] = v;
    @(posedge clock);
    ee_load <= 1'b0;
    // pass 0 writes all ones to probe sizes, later passes random
    for (int p = 0; p < 3; p++)
      for (int i = 0; i < 6; i++)
      begin
        rd(adr[i], shd[i]);
        wr(i, p == 0 ? 4'hf : 4'($random(seed)), p == 0 ? '1 : $random(seed));
      end
    foreach (adr[i])
      rd(adr[i], shd[i]);
    u_host.access(1'b1, 8'h04, 4'hf, '1);
    rd(8'h04, 32'h0);
    wr(1, 4'h2, 32'h0200);
    @(posedge clock);
    frame <= 1'b1;
    settle(2);
    chk("lat_expired", 0, lat_expired);
    settle(1);
    chk("lat_expired", 1, lat_expired);
    chk("burst_stop", 0, burst_stop);
    @(posedge clock);
    gnt_n <= 1'b1;
    #1;
    chk("burst_stop", 1, burst_stop);
    @(posedge clock);
    frame <= 1'b0;
    gnt_n <= 1'b0;
    wr(3, 4'hf, 32'h00080000);
    wr(5, 4'hf, 32'h00040001);
    @(posedge clock);
    acc <= 32'h00040010;
    settle(2);
    chk("rom_hit", 0, rom_hit);
    @(posedge clock);
    mse <= 1'b1;
    settle(2);
    chk("rom_hit", 1, rom_hit);
    @(posedge clock);
    acc <= 32'h00080004;
    settle(2);
    chk("mem_hit", 1, mem_hit);
    wr(2, 4'hf, 32'h00080000);
    ise <= 1'b1;
    mse <= 1'b0;
    settle(2);
    chk("io_hit", 1, io_hit);
    chk("mem_hit", 0, mem_hit);
    settle(3);
    chk("pending reads", 0, expq.size());
    test_done;
  end
endmodule
`default_nettype wire
